// *** src/ddr_refresh_map.svh ***
/*
  Constants for the refresh-rate controller and the refresh-rate logic of the
  memory device: timing counts, mode register fields, codes and register map.
  Assumes a 100 MHz sys_clk on both ends.
*/
`ifndef DDR_REFRESH_MAP_SVH
`define DDR_REFRESH_MAP_SVH

// Clock and refresh timing
`define CLK_PERIOD_NS   10
`define REFI_BASE_NS    7800
`define REFI_BASE_CYC   (`REFI_BASE_NS / `CLK_PERIOD_NS)
`define RFC1_NS         260
`define RFC2_NS         160
`define RFC4_NS         110
`define RFC1_CYC        ((`RFC1_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RFC2_CYC        ((`RFC2_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RFC4_CYC        ((`RFC4_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MOD_CYC         24

// Case temperature thresholds, degrees C, signed
`define TEMP_COOL_C     8'sh2d
`define TEMP_NORM_C     8'sh55
`define TEMP_HOT1_C     8'sh5f
`define TEMP_HOT2_C     8'sh69

// Mode register select and fields
`define MR_SEL_FGR      3'h3
`define MR_SEL_TCR      3'h4
`define FGR_LSB         6
`define TCR_EN_BIT      3
`define TCR_RANGE_BIT   2

// Fine granularity refresh codes
`define FGR_FIXED_1X    3'h0
`define FGR_FIXED_2X    3'h1
`define FGR_FIXED_4X    3'h2
`define FGR_OTF_1X2X    3'h5
`define FGR_OTF_1X4X    3'h6

// Controller register map
`define REG_CTRL        4'h0
`define REG_STATUS      4'h4
`define CTRL_EN_BIT     0
`define CTRL_TCR_BIT    1
`define CTRL_EXT_BIT    2
`define CTRL_OTF_HI_BIT 3
`define CTRL_FGR_LSB    4
`define CTRL_RESET      7'h00
`define STAT_KIND_LSB   8
`define STAT_COUNT_LSB  16

`endif

// *** src/ddr_refresh_pkg.sv ***
/*
  Refresh kind type shared by both ends of the refresh command link, and the controller state type.
  Assumes ddr_refresh_map.svh for all numeric constants.
*/
`default_nettype none

package ddr_refresh_pkg;

  typedef enum logic [1:0] {
    kind_1x,
    kind_2x,
    kind_4x
  } refresh_kind_type;

  typedef enum logic [2:0] {
    st_idle,
    st_mrs_off,
    st_mrs_fgr,
    st_mrs_tcr,
    st_run
  } ctrl_state_type;

endpackage

`default_nettype wire

// *** src/ddr_refresh_if.sv ***
/*
  Command bus between the refresh controller and the memory device.
  Assumes both ends run on the same sys_clk; the controller drives every signal.
*/
`timescale 1ns/10ps
`default_nettype none

interface ddr_refresh_if;
  logic       cs_n;
  logic       act_n;
  logic       ras_n;
  logic       cas_n;
  logic       we_n;
  logic       bg0;
  logic [1:0] ba;
  logic [8:0] addr;

  modport controller (output cs_n, act_n, ras_n, cas_n, we_n, bg0, ba, addr);
  modport device     (input  cs_n, act_n, ras_n, cas_n, we_n, bg0, ba, addr);
endinterface

`default_nettype wire

// *** src/refresh_device.sv ***
/*
  Refresh-rate logic of the memory device: mode register capture, refresh
  decode, on-the-fly rate sampling and temperature-geared refresh skipping.
  Assumes the controller drives the link on sys_clk and case_temp is async.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ddr_refresh_map.svh"

module refresh_device (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          sys_rst,
  // Command link
  ddr_refresh_if.device                      link,
  // Case temperature sensor
  input  wire logic signed [7:0]             case_temp,
  // Internal refresh reporting
  output var  logic                          int_refresh,
  output var  ddr_refresh_pkg::refresh_kind_type int_kind,
  output var  logic                          cmd_skipped,
  output var  logic                          tcr_active,
  output var  logic                          tcr_ext_range,
  output var  logic [2:0]                    fgr_mode,
  output var  logic                          fgr_reserved
);

  //////////////////////////////////////////////////////////////////////////////
  // Temperature synchroniser
  logic signed [7:0] temp_meta;
  logic signed [7:0] temp_sync;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      temp_meta <= 8'sh00;
      temp_sync <= 8'sh00;
    end else begin
      temp_meta <= case_temp;
      temp_sync <= temp_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command decode and refresh gearing
  logic                              is_ref;
  logic                              is_mrs;
  logic [2:0]                        mr_sel;
  logic [1:0]                        gear;
  logic [1:0]                        gear_mask;
  ddr_refresh_pkg::refresh_kind_type cmd_kind;
  logic [1:0]                        next_gear;
  logic                              next_int_refresh;
  ddr_refresh_pkg::refresh_kind_type next_int_kind;
  logic                              next_cmd_skipped;
  logic                              next_tcr_active;
  logic                              next_tcr_ext_range;
  logic [2:0]                        next_fgr_mode;
  logic                              next_fgr_reserved;

  always_comb begin
    is_ref = !link.cs_n && link.act_n && !link.ras_n && !link.cas_n && link.we_n;
    is_mrs = !link.cs_n && link.act_n && !link.ras_n && !link.cas_n && !link.we_n;
    mr_sel = {link.bg0, link.ba};
    unique case (fgr_mode)
      `FGR_FIXED_2X: cmd_kind = ddr_refresh_pkg::kind_2x;
      `FGR_FIXED_4X: cmd_kind = ddr_refresh_pkg::kind_4x;
      `FGR_OTF_1X2X: cmd_kind = link.bg0 ? ddr_refresh_pkg::kind_2x
                                         : ddr_refresh_pkg::kind_1x;
      `FGR_OTF_1X4X: cmd_kind = link.bg0 ? ddr_refresh_pkg::kind_4x
                                         : ddr_refresh_pkg::kind_1x;
      default:       cmd_kind = ddr_refresh_pkg::kind_1x;
    endcase
    gear_mask = 2'h0;
    if (tcr_active) begin
      if (tcr_ext_range) begin
        if (temp_sync < `TEMP_COOL_C) begin
          gear_mask = 2'h3;
        end else if (temp_sync <= `TEMP_NORM_C) begin
          gear_mask = 2'h1;
        end
      end else if (temp_sync < `TEMP_COOL_C) begin
        gear_mask = 2'h1;
      end
    end
    next_gear          = gear;
    next_int_refresh   = 1'b0;
    next_int_kind      = int_kind;
    next_cmd_skipped   = 1'b0;
    next_tcr_active    = tcr_active;
    next_tcr_ext_range = tcr_ext_range;
    next_fgr_mode      = fgr_mode;
    next_fgr_reserved  = fgr_reserved;
    if (is_ref) begin
      next_gear        = gear + 2'h1;
      next_int_kind    = cmd_kind;
      next_int_refresh = (gear & gear_mask) == 2'h0;
      next_cmd_skipped = (gear & gear_mask) != 2'h0;
    end else if (is_mrs && mr_sel == `MR_SEL_FGR) begin
      next_fgr_mode     = link.addr[`FGR_LSB +: 3];
      next_fgr_reserved = !(link.addr[`FGR_LSB +: 3] inside {`FGR_FIXED_1X, `FGR_FIXED_2X,
                            `FGR_FIXED_4X, `FGR_OTF_1X2X, `FGR_OTF_1X4X});
    end else if (is_mrs && mr_sel == `MR_SEL_TCR) begin
      next_tcr_active    = link.addr[`TCR_EN_BIT];
      next_tcr_ext_range = link.addr[`TCR_RANGE_BIT];
      next_gear          = 2'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      gear          <= 2'h0;
      int_refresh   <= 1'b0;
      int_kind      <= ddr_refresh_pkg::kind_1x;
      cmd_skipped   <= 1'b0;
      tcr_active    <= 1'b0;
      tcr_ext_range <= 1'b0;
      fgr_mode      <= `FGR_FIXED_1X;
      fgr_reserved  <= 1'b0;
    end else begin
      gear          <= next_gear;
      int_refresh   <= next_int_refresh;
      int_kind      <= next_int_kind;
      cmd_skipped   <= next_cmd_skipped;
      tcr_active    <= next_tcr_active;
      tcr_ext_range <= next_tcr_ext_range;
      fgr_mode      <= next_fgr_mode;
      fgr_reserved  <= next_fgr_reserved;
    end
  end

endmodule

`default_nettype wire

// *** src/refresh_controller.sv ***
/*
  Refresh controller: programs the refresh mode registers and issues REFRESH
  commands at the interval set by mode, command kind and case temperature.
  Assumes a register master on sys_clk and an async case_temp sensor.
*/
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "ddr_refresh_map.svh"

module refresh_controller (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  // Register port
  input  wire logic [3:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output var  logic [31:0]       reg_rdata,
  // Case temperature sensor
  input  wire logic signed [7:0] case_temp,
  // Command link
  ddr_refresh_if.controller      link
);

  //////////////////////////////////////////////////////////////////////////////
  // Control register and temperature synchroniser
  logic [6:0]        ctrl;
  logic [6:0]        next_ctrl;
  logic signed [7:0] temp_meta;
  logic signed [7:0] temp_sync;

  always_comb begin
    next_ctrl = ctrl;
    if (reg_wr && reg_addr == `REG_CTRL) begin
      next_ctrl = reg_wdata[6:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl      <= `CTRL_RESET;
      temp_meta <= 8'sh00;
      temp_sync <= 8'sh00;
    end else begin
      ctrl      <= next_ctrl;
      temp_meta <= case_temp;
      temp_sync <= temp_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer and command issue
  ddr_refresh_pkg::ctrl_state_type   state;
  ddr_refresh_pkg::ctrl_state_type   next_state;
  ddr_refresh_pkg::refresh_kind_type kind;
  ddr_refresh_pkg::refresh_kind_type last_kind;
  ddr_refresh_pkg::refresh_kind_type next_last_kind;
  logic [5:0]  gap_cnt;
  logic [5:0]  next_gap_cnt;
  logic [9:0]  int_cnt;
  logic [9:0]  next_int_cnt;
  logic [15:0] ref_count;
  logic [15:0] next_ref_count;
  logic [2:0]  prog_fgr;
  logic [2:0]  next_prog_fgr;
  logic        prog_tcr;
  logic        next_prog_tcr;
  logic        prog_ext;
  logic        next_prog_ext;
  logic        cfg_en;
  logic        cfg_tcr;
  logic        cfg_ext;
  logic        cfg_hi;
  logic [2:0]  cfg_fgr;
  logic        need_prog;
  logic        otf_mode;
  logic [2:0]  shift;
  logic [9:0]  interval;
  logic [5:0]  rfc_cyc;
  logic        next_cs_n;
  logic        next_act_n;
  logic        next_ras_n;
  logic        next_cas_n;
  logic        next_we_n;
  logic        next_bg0;
  logic [1:0]  next_ba;
  logic [8:0]  next_addr;

  always_comb begin
    cfg_en    = ctrl[`CTRL_EN_BIT];
    cfg_ext   = ctrl[`CTRL_EXT_BIT];
    cfg_hi    = ctrl[`CTRL_OTF_HI_BIT];
    cfg_fgr   = ctrl[`CTRL_FGR_LSB +: 3];
    cfg_tcr   = ctrl[`CTRL_TCR_BIT] && cfg_fgr == `FGR_FIXED_1X;
    need_prog = {cfg_fgr, cfg_tcr, cfg_ext} != {prog_fgr, prog_tcr, prog_ext};
    otf_mode  = prog_fgr == `FGR_OTF_1X2X || prog_fgr == `FGR_OTF_1X4X;
    unique case (prog_fgr)
      `FGR_FIXED_2X: kind = ddr_refresh_pkg::kind_2x;
      `FGR_FIXED_4X: kind = ddr_refresh_pkg::kind_4x;
      `FGR_OTF_1X2X: kind = cfg_hi ? ddr_refresh_pkg::kind_2x : ddr_refresh_pkg::kind_1x;
      `FGR_OTF_1X4X: kind = cfg_hi ? ddr_refresh_pkg::kind_4x : ddr_refresh_pkg::kind_1x;
      default:       kind = ddr_refresh_pkg::kind_1x;
    endcase
    shift     = {1'b0, kind};
    if (temp_sync > `TEMP_HOT2_C) begin
      shift = shift + 3'h3;
    end else if (temp_sync > `TEMP_HOT1_C) begin
      shift = shift + 3'h2;
    end else if (temp_sync > `TEMP_NORM_C || (prog_tcr && prog_ext)) begin
      shift = shift + 3'h1;
    end
    interval = 10'(`REFI_BASE_CYC) >> shift;
    unique case (kind)
      ddr_refresh_pkg::kind_2x: rfc_cyc = 6'(`RFC2_CYC);
      ddr_refresh_pkg::kind_4x: rfc_cyc = 6'(`RFC4_CYC);
      default:                  rfc_cyc = 6'(`RFC1_CYC);
    endcase
    next_state     = state;
    next_gap_cnt   = (gap_cnt != 6'h00) ? gap_cnt - 6'h01 : gap_cnt;
    next_int_cnt   = (int_cnt != 10'h000) ? int_cnt - 10'h001 : int_cnt;
    next_ref_count = ref_count;
    next_last_kind = last_kind;
    next_prog_fgr  = prog_fgr;
    next_prog_tcr  = prog_tcr;
    next_prog_ext  = prog_ext;
    next_cs_n      = 1'b1;
    next_act_n     = 1'b1;
    next_ras_n     = 1'b1;
    next_cas_n     = 1'b1;
    next_we_n      = 1'b1;
    next_bg0       = 1'b0;
    next_ba        = 2'h0;
    next_addr      = 9'h000;
    unique case (state)
      ddr_refresh_pkg::st_idle: next_state = cfg_en ? ddr_refresh_pkg::st_mrs_off : state;
      ddr_refresh_pkg::st_mrs_off: begin
        if (gap_cnt == 6'h00) begin
          // Temperature-controlled refresh off before any mode change
          {next_cs_n, next_ras_n, next_cas_n, next_we_n} = 4'h0;
          {next_bg0, next_ba}                     = `MR_SEL_TCR;
          next_addr[`TCR_RANGE_BIT]               = cfg_ext;
          next_prog_tcr                           = 1'b0;
          next_gap_cnt                            = 6'(`MOD_CYC - 1);
          next_state                              = ddr_refresh_pkg::st_mrs_fgr;
        end
      end
      ddr_refresh_pkg::st_mrs_fgr: begin
        if (gap_cnt == 6'h00) begin
          {next_cs_n, next_ras_n, next_cas_n, next_we_n} = 4'h0;
          {next_bg0, next_ba}                     = `MR_SEL_FGR;
          next_addr[`FGR_LSB +: 3]                = cfg_fgr;
          next_prog_fgr                           = cfg_fgr;
          next_gap_cnt                            = 6'(`MOD_CYC - 1);
          next_state                              = ddr_refresh_pkg::st_mrs_tcr;
        end
      end
      ddr_refresh_pkg::st_mrs_tcr: begin
        if (gap_cnt == 6'h00) begin
          {next_cs_n, next_ras_n, next_cas_n, next_we_n} = 4'h0;
          {next_bg0, next_ba}                     = `MR_SEL_TCR;
          next_addr[`TCR_EN_BIT]                  = cfg_tcr;
          next_addr[`TCR_RANGE_BIT]               = cfg_ext;
          next_prog_tcr                           = cfg_tcr;
          next_prog_ext                           = cfg_ext;
          next_gap_cnt                            = 6'(`MOD_CYC - 1);
          next_int_cnt                            = 10'h000;
          next_state                              = ddr_refresh_pkg::st_run;
        end
      end
      ddr_refresh_pkg::st_run: begin
        if (!cfg_en) begin
          next_state = ddr_refresh_pkg::st_idle;
        end else if (need_prog) begin
          next_state = ddr_refresh_pkg::st_mrs_off;
        end else if (gap_cnt == 6'h00 && int_cnt == 10'h000) begin
          {next_cs_n, next_ras_n, next_cas_n} = 3'h0;
          next_bg0       = otf_mode && kind != ddr_refresh_pkg::kind_1x;
          next_gap_cnt   = rfc_cyc - 6'h01;
          next_int_cnt   = interval - 10'h001;
          next_last_kind = kind;
          next_ref_count = ref_count + 16'h0001;
        end
      end
      default: next_state = ddr_refresh_pkg::st_idle;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state      <= ddr_refresh_pkg::st_idle;
      gap_cnt    <= 6'h00;
      int_cnt    <= 10'h000;
      ref_count  <= 16'h0000;
      last_kind  <= ddr_refresh_pkg::kind_1x;
      prog_fgr   <= `FGR_FIXED_1X;
      prog_tcr   <= 1'b0;
      prog_ext   <= 1'b0;
      link.cs_n  <= 1'b1;
      link.act_n <= 1'b1;
      link.ras_n <= 1'b1;
      link.cas_n <= 1'b1;
      link.we_n  <= 1'b1;
      link.bg0   <= 1'b0;
      link.ba    <= 2'h0;
      link.addr  <= 9'h000;
    end else begin
      state      <= next_state;
      gap_cnt    <= next_gap_cnt;
      int_cnt    <= next_int_cnt;
      ref_count  <= next_ref_count;
      last_kind  <= next_last_kind;
      prog_fgr   <= next_prog_fgr;
      prog_tcr   <= next_prog_tcr;
      prog_ext   <= next_prog_ext;
      link.cs_n  <= next_cs_n;
      link.act_n <= next_act_n;
      link.ras_n <= next_ras_n;
      link.cas_n <= next_cas_n;
      link.we_n  <= next_we_n;
      link.bg0   <= next_bg0;
      link.ba    <= next_ba;
      link.addr  <= next_addr;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register read port
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        `REG_CTRL: next_rdata[6:0] = ctrl;
        `REG_STATUS: begin
          next_rdata[0]                    = state == ddr_refresh_pkg::st_run;
          next_rdata[1]                    = prog_tcr;
          next_rdata[2]                    = prog_ext;
          next_rdata[6:4]                  = prog_fgr;
          next_rdata[`STAT_KIND_LSB +: 2]  = last_kind;
          next_rdata[`STAT_COUNT_LSB +: 16] = ref_count;
        end
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

endmodule

`default_nettype wire

// *** tb/refresh_link_properties.sv ***
/*
  Checker for the refresh command link between controller and device.
  Assumes it is instantiated beside the link interface, on sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ddr_refresh_map.svh"

module refresh_link_properties (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  // Command link
  input wire logic       cs_n,
  input wire logic       act_n,
  input wire logic       ras_n,
  input wire logic       cas_n,
  input wire logic       we_n,
  input wire logic       bg0,
  input wire logic [1:0] ba,
  input wire logic [8:0] addr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////
  // Link state tracking
  logic        link_idle;
  logic        is_ref;
  logic        is_mrs;
  logic        is_mr3;
  logic        is_mr4;
  logic [2:0]  fgr;
  logic        temp_ctrl_refresh;
  logic        ext;
  logic        mr4_off;
  logic [1:0]  last_cmd;
  logic [1:0]  kind;
  logic [1:0]  last_kind;
  logic [10:0] gap;
  int          rfc_min;
  int          gap_max;

  assign link_idle = act_n && ras_n && cas_n && we_n && !bg0 && ba == 2'h0 && addr == 9'h0;
  assign is_ref  = !cs_n && !ras_n && !cas_n && we_n;
  assign is_mrs  = !cs_n && !ras_n && !cas_n && !we_n;
  assign is_mr3  = is_mrs && {bg0, ba} == 3'h3;
  assign is_mr4  = is_mrs && {bg0, ba} == 3'h4;
  assign kind    = (fgr == 3'h1 || (fgr == 3'h5 && bg0)) ? 2'h1 : (fgr == 3'h2 || (fgr == 3'h6 && bg0)) ? 2'h2 : 2'h0;
  assign rfc_min = last_kind == 2'h2 ? `RFC4_CYC : last_kind == 2'h1 ? `RFC2_CYC : `RFC1_CYC;
  assign gap_max = (temp_ctrl_refresh && ext) ? 390 : `REFI_BASE_CYC >> kind;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fgr       <= 3'h0;
      temp_ctrl_refresh       <= 1'b0;
      ext       <= 1'b0;
      mr4_off   <= 1'b0;
      last_cmd  <= 2'h0;
      last_kind <= 2'h0;
      gap       <= 11'h0;
    end else begin
      gap <= !cs_n ? 11'h1 : (gap == 11'h7ff ? gap : gap + 11'h1);
      if (is_mr3) fgr <= addr[8:6];
      if (is_mr4) temp_ctrl_refresh <= addr[3];
      if (is_mr4) ext <= addr[2];
      if (is_mrs) mr4_off <= is_mr4 && !addr[3];
      if (is_mrs) last_cmd <= is_mr4 ? 2'h1 : 2'h2;
      if (is_ref) last_cmd <= 2'h3;
      if (is_ref) last_kind <= kind;
    end
  end

  ////////////////////////////////////////
  // Properties
  sequence s_refresh;
    is_ref;
  endsequence
  sequence s_mode_write;
    is_mrs;
  endsequence

  chk_idle_levels: assert property (cs_n |-> link_idle)
    else $error("link not idle between commands");
  chk_cmd_shape: assert property (!cs_n |-> act_n && !ras_n && !cas_n)
    else $error("command encoding wrong");
  chk_refresh_recovery: assert property (s_refresh |-> last_cmd != 2'h3 || gap >= rfc_min)
    else $error("refresh inside recovery time");
  chk_refresh_interval: assert property (s_refresh |-> last_cmd != 2'h3 || gap <= gap_max)
    else $error("refresh interval too long");
  chk_ext_period: assert property (s_refresh |-> !(temp_ctrl_refresh && ext) || last_cmd != 2'h3 || gap <= 390)
    else $error("extended range period above limit");
  chk_mode_spacing: assert property (!cs_n && last_cmd inside {2'h1, 2'h2} |-> gap >= `MOD_CYC)
    else $error("command too soon after mode write");
  chk_temp_fixed_only: assert property (s_mode_write |-> !(is_mr4 && addr[3]) || fgr == 3'h0)
    else $error("temperature refresh with non 1x mode");
  chk_fine_after_off: assert property (is_mr3 |-> mr4_off)
    else $error("fine grain write without disable first");
  chk_fixed_rate_bg0: assert property (s_refresh |-> fgr[2] || !bg0)
    else $error("rate select in fixed mode");
  chk_refresh_setup: assert property (s_refresh |-> last_cmd inside {2'h1, 2'h3})
    else $error("refresh before mode setup done");
  cover property (s_mode_write ##[1:100] s_refresh);
endmodule

`default_nettype wire

// *** tb/test_dram_refresh_rate_control.sv ***
/*
  Self-checking bench: controller and device joined by the refresh link.
  Assumes the src design files and the link checker are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none

module test_dram_refresh_rate_control;
  typedef struct {logic [31:0] v; logic [31:0] m;} rd_note_type;
  typedef struct {logic s; logic [1:0] k; int g;} ev_note_type;
  logic                              sys_clk = 1'b0;
  logic                              sys_rst = 1'b1;
  logic [3:0]                        reg_addr = 4'h0;
  logic [31:0]                       reg_wdata = 32'h0;
  logic                              reg_wr = 1'b0;
  logic                              reg_rd = 1'b0;
  logic [31:0]                       reg_rdata;
  logic signed [7:0]                 case_temp = 8'sh1e;
  logic                              int_refresh;
  logic                              cmd_skipped;
  logic                              tcr_active;
  logic                              tcr_ext_range;
  logic                              fgr_reserved;
  logic [2:0]                        fgr_mode;
  ddr_refresh_pkg::refresh_kind_type int_kind;
  int                                n_errors = 0;
  int                                compares = 0;
  int                                cyc = 0;
  int                                last_ev = 0;
  logic                              rd_pend = 1'b0;
  rd_note_type                       rd_q[$];
  ev_note_type                       ev_q[$];
  rd_note_type                       r;
  ev_note_type                       e;
  logic [31:0]                       v;
  // Rows: control word, temperature base, kind, interval, skip mask
  logic [6:0] t_ctrl [17] = '{7'h05, 7'h03, 7'h03, 7'h07, 7'h07, 7'h07, 7'h01, 7'h01, 7'h13, 7'h21, 7'h51,
                              7'h59, 7'h69, 7'h61, 7'h31, 7'h41, 7'h71};
  int         t_temp [17] = '{30, 30, 60, 30, 60, 86, 96, 106, 30, 96, 30, 86, 30, 30, 30, 30, 30};
  logic [1:0] t_kind [17] = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 2, 0, 1, 2, 0, 0, 0, 0};
  int         t_gap  [17] = '{780, 780, 780, 390, 390, 390, 195, 97, 390, 48, 780, 195, 195, 780, 780, 780, 780};
  int         t_mask [17] = '{0, 1, 0, 3, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  ddr_refresh_if link_bus ();
  refresh_controller i_refresh_controller (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .case_temp(case_temp),
    .link(link_bus));
  refresh_device i_refresh_device (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link_bus), .case_temp(case_temp),
    .int_refresh(int_refresh), .int_kind(int_kind), .cmd_skipped(cmd_skipped), .tcr_active(tcr_active),
    .tcr_ext_range(tcr_ext_range), .fgr_mode(fgr_mode), .fgr_reserved(fgr_reserved));
  refresh_link_properties i_refresh_link_properties (.sys_clk(sys_clk), .sys_rst(sys_rst), .cs_n(link_bus.cs_n),
    .act_n(link_bus.act_n), .ras_n(link_bus.ras_n), .cas_n(link_bus.cas_n), .we_n(link_bus.we_n),
    .bg0(link_bus.bg0), .ba(link_bus.ba), .addr(link_bus.addr));

  ////////////////////////////////////////
  // Checking and closing
  task automatic fail(input string msg);
    n_errors++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask
  task automatic chk(input logic c, input string msg);
    compares++;
    if (!c) fail(msg);
  endtask
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    rd_pend <= reg_rd;
    if (rd_pend && rd_q.size() != 0) begin
      r = rd_q.pop_front();
      chk((reg_rdata & r.m) === r.v, "register read value");
    end
    if (int_refresh === 1'b1 || cmd_skipped === 1'b1) begin
      if (ev_q.size() == 0) begin
        fail("unexpected refresh");
      end else begin
        e = ev_q.pop_front();
        chk(cmd_skipped === e.s && int_refresh === !e.s, "refresh skip");
        chk(int_kind === e.k, "refresh kind");
        chk(e.g == 0 || cyc - last_ev == e.g, "refresh interval");
      end
      last_ev = cyc;
    end
  end

  ////////////////////////////////////////
  // Register port driver
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] x, input logic [31:0] m);
    rd_q.push_back('{x, m});
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
  endtask

  task automatic run_row(input int i);
    logic [2:0] code;
    logic       tcr_eff;
    int         n;
    code    = t_ctrl[i][6:4];
    tcr_eff = t_ctrl[i][1] && code == 3'h0;
    case_temp <= 8'(t_temp[i] + $urandom % 10);
    repeat (5) @(posedge sys_clk);
    for (n = 0; n < 5; n++) ev_q.push_back('{(n & t_mask[i]) != 0, t_kind[i], n == 0 ? 0 : t_gap[i]});
    wr(4'h0, {25'h0, t_ctrl[i]});
    repeat (6000) if (ev_q.size() != 0) @(posedge sys_clk);
    chk(ev_q.size() == 0, "refreshes missing");
    chk(tcr_active === tcr_eff, "temperature mode");
    chk(tcr_ext_range === t_ctrl[i][2], "range bit");
    chk(fgr_mode === code, "fine grain code");
    chk(fgr_reserved === (code inside {3'h3, 3'h4, 3'h7}), "reserved flag");
    rd(4'h4, {16'(5 * (i + 1)), 6'h0, t_kind[i], 1'b0, code, 1'b0, t_ctrl[i][2], tcr_eff, 1'b1},
       32'hffff_0377);
    ev_q.delete();
    wr(4'h0, 32'h0);
    repeat (30) @(posedge sys_clk);
    $display("Test row %0d done", i);
  endtask

  initial begin
    void'($urandom(84));
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(4'h0, 32'h0, 32'hffffffff);
    rd(4'h4, 32'h0, 32'hffffffff);
    wr(4'h8, $urandom);
    rd(4'h8, 32'h0, 32'hffffffff);
    v = $urandom & 32'h7e;
    wr(4'h0, v);
    rd(4'h0, v, 32'h7f);
    wr(4'h0, 32'h0);
    $display("Test registers done");
    for (int i = 0; i < 17; i++) run_row(i);
    ev_q.push_back('{1'b0, 2'h0, 0});
    wr(4'h0, 32'h01);
    repeat (1000) if (ev_q.size() != 0) @(posedge sys_clk);
    for (int n = 0; n < 3; n++) ev_q.push_back('{1'b0, 2'h1, n == 0 ? 0 : 390});
    wr(4'h0, 32'h11);
    repeat (2000) if (ev_q.size() != 0) @(posedge sys_clk);
    chk(ev_q.size() == 0, "rate change while running");
    chk(fgr_mode === 3'h1, "fine grain code after change");
    wr(4'h0, 32'h0);
    repeat (30) @(posedge sys_clk);
    $display("Test rate change done");
    results();
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    fail("watchdog expired");
    results();
  end
endmodule

`default_nettype wire
